// File: common/atf_pkg.sv
// Constants and carrier types of the task file register bank
package atf_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] OFS_DATA = 4'h0; // Data word, also high-lane error/feature
   localparam logic [3:0] OFS_ERR_FEAT = 4'h1; // Error read, feature write
   localparam logic [3:0] OFS_COUNT = 4'h2; // Sector count
   localparam logic [3:0] OFS_SECTOR = 4'h3; // Sector number, block bits 7-0
   localparam logic [3:0] OFS_CYL_LO = 4'h4; // Cylinder low, block bits 15-8
   localparam logic [3:0] OFS_CYL_HI = 4'h5; // Cylinder high, block bits 23-16
   localparam logic [3:0] OFS_DRV_HEAD = 4'h6; // Drive and head select
   localparam logic [3:0] OFS_STATUS = 4'h7; // Status read, command write
   localparam logic [3:0] OFS_DUP_ERR = 4'hd; // Duplicate error/feature
   localparam logic [3:0] OFS_ALT_CTL = 4'he; // Alternate status, device control
   localparam logic [3:0] OFS_DRV_ADDR = 4'hf; // Drive address readback
   // ****************************************
   // Field positions
   // ****************************************
   localparam int ERR_BAD_BLOCK = 7; // bad_block_or_link_crc_flag
   localparam int ERR_ECC_FAIL = 6; // ecc_failure_flag
   localparam int ERR_NOT_FOUND = 4; // sector_not_found_flag
   localparam int ERR_ABORT = 2; // command_abort_flag
   localparam int ERR_GENERAL = 0; // general_error_flag
   localparam logic [7:0] ERR_KEEP_MASK = 8'hd5; // Bits 5, 3 and 1 read zero
   localparam int DH_LBA = 6; // Block addressing select
   localparam int DH_DRIVE = 4; // drive_select_bit
   localparam int CTL_SRST = 2; // soft_reset_bit
   localparam int CTL_NIEN = 1; // interrupt_mask_bit
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_COUNT = 8'h01; // Count after reset
   localparam logic [7:0] RST_SECTOR = 8'h01; // Sector after reset
   localparam logic [7:0] RST_ZERO = 8'h00; // Other task file bytes
   localparam logic [7:0] RST_DRV_HEAD = 8'ha0; // Fixed ones in bits 7 and 5
   localparam logic [8:0] FULL_COUNT = 9'h100; // Count of zero means 256
   // ****************************************
   // Carrier types
   // ****************************************
   // Status as read by the host
   typedef struct packed {
      logic busy;
      logic ready;
      logic write_fault;
      logic seek_complete;
      logic transfer_request;
      logic fixed_data;
      logic index;
      logic error;
   } atf_status_t;
   // State and events from the command engine
   typedef struct packed {
      logic busy;
      logic ready;
      logic write_fault;
      logic xfer_req;
      logic corrected;
      logic write_active;
      logic dma_want;
      logic irq_evt;
      logic done;
      logic failed;
      logic [7:0] err_bits;
   } atf_core_t;
   // Task file contents written back by the engine
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] sector;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [3:0] head;
   } atf_tf_t;
endpackage

// File: rtl/atf_task_file.sv
// Task file register bank between host bus and command engine
`timescale 1ns/100ps
// Operation
// R01 - Error register read-only, bits 5,3,1 zero
// R02 - Bit 7 on bad block or CRC
// R03 - Bits 6,4,0: ECC, not found, general
// R04 - Bit 2 on aborted command
// R05 - High-lane offset 0 reaches error/feature
// R06 - Sector count zero means 256 sectors
// R07 - Count zero on success, remainder on failure
// R08 - Bit 6 selects block addressing; head bits
// R09 - 28-bit block address from four registers
// R10 - Bit 4 selects drive 0 or 1
// R11 - Status read clears interrupt; alternate does not
// R12 - Busy locks host out of command registers
// R13 - DMA request only while busy or transfer
// R14 - Ready clear until commands accepted
// R15 - Write fault and ready status bits
// R16 - Transfer request bit while data moves
// R17 - Corrected bit, bit 1 reads zero
// R18 - Error bit on failed command; keep address
// R19 - Device control writable while busy
// R20 - Soft reset held while bit set
// R21 - Interrupt mask bit, reset to zero
// R22 - Drive address readback inverted fields
module atf_task_file (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host register port
   input wire logic [3:0] hst_addr,
   input wire logic hst_rd,
   input wire logic hst_wr,
   input wire logic low_byte_enable_n,
   input wire logic high_byte_enable_n,
   input wire logic [15:0] hst_wdata,
   output logic [15:0] hst_rdata,
   output logic hst_rdata_oe,
   output logic host_irq,
   // Command engine side
   input wire atf_pkg::atf_core_t core_in,
   input wire logic tf_load,
   input wire atf_pkg::atf_tf_t tf_in,
   output logic cmd_strobe,
   output logic [7:0] cmd_code,
   output logic [7:0] feature_out,
   output logic lba_mode,
   output logic [27:0] block_addr,
   output logic [3:0] head_num,
   output logic [8:0] sector_total,
   output logic drive_select_bit,
   output logic soft_reset_bit,
   output logic dma_req
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] error_detail_r; // Error detail
   logic [7:0] feature_select_r; // Feature byte
   logic [7:0] sector_count_r; // Sector count
   logic [7:0] sector_number_r; // Sector number
   logic [7:0] cyl_low_r; // Cylinder low
   logic [7:0] cyl_high_r; // Cylinder high
   logic [7:0] drive_head_r; // Drive and head
   logic error_flag_r; // Status error bit
   logic soft_reset_r; // Device control soft reset
   logic interrupt_mask_r; // Device control interrupt disable
   logic int_pend_r; // Pending interrupt
   logic cmd_strobe_r; // Command written pulse
   logic [7:0] cmd_code_r; // Last command code
   logic [15:0] rdata_r; // Read data
   logic rdata_oe_r; // Read data valid
   // ****************************************
   // Access decode
   // ****************************************
   logic lane_ok; // At least one byte lane enabled
   logic high_only; // Only the high lane enabled
   logic [3:0] reg_sel; // Effective register offset
   logic [7:0] wbyte; // Byte written from the active lane
   logic wr_ok; // Register write accepted
   logic wr_cmd_blk; // Write to the command block
   logic rd_ok; // Register read accepted
   logic status_rd; // Read of primary status
   atf_pkg::atf_status_t status_now; // Live status byte
   logic [7:0] rbyte; // Byte selected for reading
   assign lane_ok = !(low_byte_enable_n && high_byte_enable_n);
   assign high_only = low_byte_enable_n && !high_byte_enable_n;
   // Offset 0 on the high lane only is the error/feature pair
   always_comb begin
      reg_sel = hst_addr;
      if (hst_addr == atf_pkg::OFS_DATA && high_only) begin
         reg_sel = atf_pkg::OFS_ERR_FEAT; // R05
      end else if (hst_addr == atf_pkg::OFS_DUP_ERR) begin
         reg_sel = atf_pkg::OFS_ERR_FEAT;
      end
   end
   // High lane carries the byte when the low lane is off
   assign wbyte = low_byte_enable_n ? hst_wdata[15:8] : hst_wdata[7:0]; // R05
   assign wr_ok = hst_wr && lane_ok;
   assign rd_ok = hst_rd && lane_ok;
   // Command block writes are refused while the engine is busy
   assign wr_cmd_blk = wr_ok && !core_in.busy && !soft_reset_r // R12
      && reg_sel >= atf_pkg::OFS_ERR_FEAT && reg_sel <= atf_pkg::OFS_STATUS;
   assign status_rd = rd_ok && reg_sel == atf_pkg::OFS_STATUS;
   // ****************************************
   // Status byte
   // ****************************************
   always_comb begin
      status_now.busy = core_in.busy || soft_reset_r; // R12
      status_now.ready = core_in.ready && !soft_reset_r; // R14
      status_now.write_fault = core_in.write_fault; // R15
      status_now.seek_complete = core_in.ready && !soft_reset_r; // R15
      status_now.transfer_request = core_in.xfer_req; // R16
      status_now.fixed_data = core_in.corrected; // R17
      status_now.index = 1'b0; // R17
      status_now.error = error_flag_r; // R18
   end
   // ****************************************
   // Task file bytes
   // ****************************************
   // Host writes, engine write-back, soft reset defaults
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         feature_select_r <= atf_pkg::RST_ZERO;
         sector_count_r <= atf_pkg::RST_COUNT;
         sector_number_r <= atf_pkg::RST_SECTOR;
         cyl_low_r <= atf_pkg::RST_ZERO;
         cyl_high_r <= atf_pkg::RST_ZERO;
         drive_head_r <= atf_pkg::RST_DRV_HEAD;
      end else if (soft_reset_r) begin
         // Controller held in reset
         feature_select_r <= atf_pkg::RST_ZERO; // R20
         sector_count_r <= atf_pkg::RST_COUNT;
         sector_number_r <= atf_pkg::RST_SECTOR;
         cyl_low_r <= atf_pkg::RST_ZERO;
         cyl_high_r <= atf_pkg::RST_ZERO;
         drive_head_r <= atf_pkg::RST_DRV_HEAD;
      end else if (tf_load) begin
         // Remaining count and first failing address
         sector_count_r <= tf_in.count; // R07
         sector_number_r <= tf_in.sector; // R18
         cyl_low_r <= tf_in.cyl_lo;
         cyl_high_r <= tf_in.cyl_hi;
         drive_head_r[3:0] <= tf_in.head;
      end else if (wr_cmd_blk) begin
         unique case (reg_sel)
            atf_pkg::OFS_ERR_FEAT: begin
               feature_select_r <= wbyte;
            end
            atf_pkg::OFS_COUNT: begin
               sector_count_r <= wbyte;
            end
            atf_pkg::OFS_SECTOR: begin
               sector_number_r <= wbyte;
            end
            atf_pkg::OFS_CYL_LO: begin
               cyl_low_r <= wbyte;
            end
            atf_pkg::OFS_CYL_HI: begin
               cyl_high_r <= wbyte;
            end
            atf_pkg::OFS_DRV_HEAD: begin
               drive_head_r <= wbyte; // R08 R10
            end
            default: begin
               // Command register handled elsewhere
            end
         endcase
      end
   end
   // ****************************************
   // Command register
   // ****************************************
   // One-cycle strobe to the engine with the code
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_strobe_r <= 1'b0;
         cmd_code_r <= atf_pkg::RST_ZERO;
      end else begin
         cmd_strobe_r <= wr_cmd_blk && reg_sel == atf_pkg::OFS_STATUS;
         if (wr_cmd_blk && reg_sel == atf_pkg::OFS_STATUS) begin
            cmd_code_r <= wbyte;
         end
      end
   end
   // ****************************************
   // Error detail and error status
   // ****************************************
   // New command clears; a failing completion in the same cycle wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         error_detail_r <= atf_pkg::RST_ZERO;
         error_flag_r <= 1'b0;
      end else if (soft_reset_r) begin
         error_detail_r <= atf_pkg::RST_ZERO;
         error_flag_r <= 1'b0;
      end else if (core_in.done && core_in.failed) begin
         // Bad block, ECC, not found, abort, general
         error_detail_r <= core_in.err_bits & atf_pkg::ERR_KEEP_MASK; // R01 R02 R03 R04
         error_flag_r <= 1'b1; // R18
      end else if (core_in.done || (wr_cmd_blk && reg_sel == atf_pkg::OFS_STATUS)) begin
         error_detail_r <= atf_pkg::RST_ZERO;
         error_flag_r <= 1'b0;
      end
   end
   // ****************************************
   // Device control
   // ****************************************
   // Accepted even while busy; unused bits ignored
   // Soft reset leaves the mask alone
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         soft_reset_r <= 1'b0;
         interrupt_mask_r <= 1'b0; // R21
      end else if (wr_ok && reg_sel == atf_pkg::OFS_ALT_CTL) begin
         soft_reset_r <= wbyte[atf_pkg::CTL_SRST]; // R19 R20
         interrupt_mask_r <= wbyte[atf_pkg::CTL_NIEN]; // R21
      end
   end
   // ****************************************
   // Interrupt
   // ****************************************
   // Status read clears; a new event in the same cycle wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_pend_r <= 1'b0;
      end else if (soft_reset_r) begin
         int_pend_r <= 1'b0;
      end else if (core_in.irq_evt) begin
         int_pend_r <= 1'b1;
      end else if (status_rd) begin
         int_pend_r <= 1'b0; // R11
      end
   end
   // Mask hides the line, keeps the flag
   assign host_irq = int_pend_r && !interrupt_mask_r; // R21
   // ****************************************
   // Read path
   // ****************************************
   // Select the byte for the decoded offset
   always_comb begin
      rbyte = atf_pkg::RST_ZERO;
      unique case (reg_sel)
         atf_pkg::OFS_ERR_FEAT: begin
            rbyte = error_detail_r; // R01
         end
         atf_pkg::OFS_COUNT: begin
            rbyte = sector_count_r;
         end
         atf_pkg::OFS_SECTOR: begin
            rbyte = sector_number_r;
         end
         atf_pkg::OFS_CYL_LO: begin
            rbyte = cyl_low_r;
         end
         atf_pkg::OFS_CYL_HI: begin
            rbyte = cyl_high_r;
         end
         atf_pkg::OFS_DRV_HEAD: begin
            rbyte = drive_head_r;
         end
         atf_pkg::OFS_STATUS, atf_pkg::OFS_ALT_CTL: begin
            rbyte = status_now; // R11
         end
         atf_pkg::OFS_DRV_ADDR: begin
            // Write flag, inverted head, active-low drive selects
            rbyte = {1'b0, !core_in.write_active, ~drive_head_r[3:0], // R22
               !drive_head_r[atf_pkg::DH_DRIVE], drive_head_r[atf_pkg::DH_DRIVE]};
         end
         default: begin
            // Data port lives outside; reads zero here
            rbyte = atf_pkg::RST_ZERO;
         end
      endcase
   end
   // Data appears on the same lane it was asked on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 16'h0000;
         rdata_oe_r <= 1'b0;
      end else begin
         rdata_oe_r <= rd_ok;
         if (rd_ok) begin
            rdata_r <= low_byte_enable_n ? {rbyte, 8'h00} : {8'h00, rbyte}; // R05
         end
      end
   end
   assign hst_rdata = rdata_r;
   assign hst_rdata_oe = rdata_oe_r;
   // ****************************************
   // Engine outputs
   // ****************************************
   assign cmd_strobe = cmd_strobe_r;
   assign cmd_code = cmd_code_r;
   assign feature_out = feature_select_r;
   assign lba_mode = drive_head_r[atf_pkg::DH_LBA]; // R08
   assign head_num = drive_head_r[3:0]; // R08
   assign block_addr = {drive_head_r[3:0], cyl_high_r, cyl_low_r, sector_number_r}; // R09
   // Zero count stands for 256
   assign sector_total = (sector_count_r == 8'h00) ? atf_pkg::FULL_COUNT
      : {1'b0, sector_count_r}; // R06
   assign drive_select_bit = drive_head_r[atf_pkg::DH_DRIVE]; // R10
   assign soft_reset_bit = soft_reset_r; // R20
   assign dma_req = core_in.dma_want && (core_in.busy || core_in.xfer_req); // R13
   // ****************************************
   // Assertions
   // ****************************************
   // Failed completion latches detail
   a_err_capture: assert property (@(posedge clk) disable iff (!rstn) // R03
      core_in.done && core_in.failed && !soft_reset_r
      |=> error_detail_r == ($past(core_in.err_bits) & 8'hd5) && error_flag_r)
      else $error("Error detail not captured on failed command");
   // Reserved error bits on both lanes
   a_err_zero_bits: assert property (@(posedge clk) disable iff (!rstn) // R01
      rd_ok && reg_sel == atf_pkg::OFS_ERR_FEAT
      |=> (rdata_r[5] | rdata_r[3] | rdata_r[1] | rdata_r[13] | rdata_r[11]
      | rdata_r[9]) == 1'b0)
      else $error("Reserved error bits read nonzero");
   // Read type decides clearing
   a_irq_clear: assert property (@(posedge clk) disable iff (!rstn) // R11
      status_rd && !core_in.irq_evt |=> !int_pend_r && !host_irq)
      else $error("Status read left interrupt pending");
   a_alt_keeps: assert property (@(posedge clk) disable iff (!rstn) // R11
      int_pend_r && rd_ok && reg_sel == atf_pkg::OFS_ALT_CTL && !soft_reset_r
      |=> int_pend_r)
      else $error("Alternate status read cleared interrupt");
   // DMA request follows visible status
   a_dma_gate: assert property (@(posedge clk) disable iff (!rstn) // R13
      dma_req |-> status_now.busy || status_now.transfer_request)
      else $error("DMA request without busy or transfer request");
   // Full count
   a_count_full: assert property (@(posedge clk) disable iff (!rstn) // R06
      sector_count_r == 8'h00 |-> sector_total == 9'h100)
      else $error("Zero count not taken as 256");
   // Busy lockout of the task file
   a_busy_lock: assert property (@(posedge clk) disable iff (!rstn) // R12
      wr_ok && core_in.busy && !tf_load && reg_sel == atf_pkg::OFS_SECTOR
      |=> $stable(sector_number_r) && !cmd_strobe_r)
      else $error("Command block written while busy");
   // Control still taken while busy
   a_ctl_busy: assert property (@(posedge clk) disable iff (!rstn) // R19
      wr_ok && core_in.busy && reg_sel == atf_pkg::OFS_ALT_CTL
      |=> soft_reset_r == $past(wbyte[2]) && interrupt_mask_r == $past(wbyte[1]))
      else $error("Device control ignored while busy");
   // Soft reset shows busy
   a_srst_ready: assert property (@(posedge clk) disable iff (!rstn) // R14
      soft_reset_r |-> !status_now.ready && status_now.busy)
      else $error("Ready shown during soft reset");
   // Block address wiring
   a_lba_build: assert property (@(posedge clk) disable iff (!rstn) // R09
      block_addr[27:24] == drive_head_r[3:0] && block_addr[7:0] == sector_number_r
      && block_addr[23:16] == cyl_high_r
      && block_addr[15:8] == cyl_low_r)
      else $error("Block address misassembled");
   // Soft reset defaults
   a_srst_hold: assert property (@(posedge clk) disable iff (!rstn) // R20
      soft_reset_r |=> sector_count_r == atf_pkg::RST_COUNT && !error_flag_r)
      else $error("Soft reset defaults lost");
   // Command handed on
   a_cmd_pulse: assert property (@(posedge clk) disable iff (!rstn) // R12
      wr_cmd_blk && reg_sel == atf_pkg::OFS_STATUS |=> cmd_strobe && cmd_code == $past(wbyte))
      else $error("Command not handed on");
   // Count write-back
   a_count_left: assert property (@(posedge clk) disable iff (!rstn) // R07
      tf_load && !soft_reset_r |=> sector_count_r == $past(tf_in.count))
      else $error("Count not loaded");
   // Inverted head readback
   a_addr_read: assert property (@(posedge clk) disable iff (!rstn) // R22
      rd_ok && !low_byte_enable_n && reg_sel == atf_pkg::OFS_DRV_ADDR
      |=> hst_rdata[5:2] == ~$past(drive_head_r[3:0]))
      else $error("Head readback wrong");
endmodule

// File: bench/atf_host_model.sv
// Host bus model that issues byte reads and writes to the task file
`timescale 1ns/100ps
module atf_host_model (
   // Clock
   input wire logic clk,
   // Host bus toward the card
   output logic [3:0] hst_addr,
   output logic hst_rd,
   output logic hst_wr,
   output logic low_byte_enable_n,
   output logic high_byte_enable_n,
   output logic [15:0] hst_wdata,
   // Answers from the card
   input wire logic [15:0] hst_rdata,
   input wire logic hst_rdata_oe
);
   // ****************************************
   // Idle bus
   // ****************************************
   // Both lanes off and no strobe from time zero
   initial begin
      hst_addr = 4'h0;
      hst_rd = 1'b0;
      hst_wr = 1'b0;
      low_byte_enable_n = 1'b1;
      high_byte_enable_n = 1'b1;
      hst_wdata = 16'h0000;
   end
   // ****************************************
   // One byte access
   // ****************************************
   // Drive just after an edge, hold for the taking edge, then release
   task automatic access(input logic [3:0] a, input logic hi, input logic wr,
                         input logic [15:0] d, output logic [15:0] q, output logic oe);
      @(posedge clk);
      #1;
      hst_addr = a;
      low_byte_enable_n = hi; // Low lane unless the high lane is asked
      high_byte_enable_n = ~hi;
      hst_wdata = d;
      hst_rd = ~wr;
      hst_wr = wr;
      @(posedge clk);
      #1;
      q = hst_rdata;
      oe = hst_rdata_oe;
      hst_rd = 1'b0;
      hst_wr = 1'b0;
      low_byte_enable_n = 1'b1;
      high_byte_enable_n = 1'b1;
      hst_wdata = ~d; // Released lines no longer show the last value
   endtask
endmodule

// File: bench/ata_task_file_registers_bench.sv
// Self-checking bench of the task file register bank
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module ata_task_file_registers_bench;
   // ****************************************
   // Signals
   // ****************************************
   logic clk; // 100 MHz clock
   logic rstn; // Active low reset
   logic [3:0] hst_addr;
   logic hst_rd;
   logic hst_wr;
   logic low_byte_enable_n;
   logic high_byte_enable_n;
   logic [15:0] hst_wdata;
   logic [15:0] hst_rdata;
   logic hst_rdata_oe;
   logic host_irq;
   atf_pkg::atf_core_t core_r; // Engine state driven by the bench
   logic tf_load;
   atf_pkg::atf_tf_t tf_r; // Engine write-back values
   logic cmd_strobe;
   logic [7:0] cmd_code;
   logic [7:0] feature_out;
   logic lba_mode;
   logic [27:0] block_addr;
   logic [3:0] head_num;
   logic [8:0] sector_total;
   logic drive_select_bit;
   logic soft_reset_bit;
   logic dma_req;
   int bad_count = 0; // Mismatches
   int checked = 0; // Comparisons
   int cycles = 0; // Timeout counter
   logic [3:0] row_addr [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6};
   logic [7:0] row_data [6] = '{8'h00, 8'h78, 8'h56, 8'h34, 8'hf2, 8'he5};
   // ****************************************
   // Instances
   // ****************************************
   atf_host_model host (.clk(clk), .hst_addr(hst_addr), .hst_rd(hst_rd), .hst_wr(hst_wr),
      .low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
      .hst_wdata(hst_wdata), .hst_rdata(hst_rdata), .hst_rdata_oe(hst_rdata_oe));
   atf_task_file DUT (.clk(clk), .rstn(rstn), .hst_addr(hst_addr), .hst_rd(hst_rd),
      .hst_wr(hst_wr), .low_byte_enable_n(low_byte_enable_n),
      .high_byte_enable_n(high_byte_enable_n), .hst_wdata(hst_wdata), .hst_rdata(hst_rdata),
      .hst_rdata_oe(hst_rdata_oe), .host_irq(host_irq), .core_in(core_r), .tf_load(tf_load),
      .tf_in(tf_r), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .feature_out(feature_out),
      .lba_mode(lba_mode), .block_addr(block_addr), .head_num(head_num),
      .sector_total(sector_total), .drive_select_bit(drive_select_bit),
      .soft_reset_bit(soft_reset_bit), .dma_req(dma_req));
   // ****************************************
   // Clock and timeout
   // ****************************************
   // Free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   // Closing report
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Low lane register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [15:0] q;
      logic oe;
      host.access(a, 1'b0, 1'b1, {8'h00, d}, q, oe);
   endtask
   // Read and compare the whole returned word
   task automatic rd_chk(input logic [3:0] a, input logic hi, input logic [15:0] e);
      logic [15:0] q;
      logic oe;
      host.access(a, hi, 1'b0, 16'h0000, q, oe);
      `CHK(oe, 1'b1)
      `CHK(q, e)
   endtask
   // Engine completion with write-back of the count
   task automatic engine(input logic d, input logic f, input logic ev, input logic [7:0] eb,
                         input logic [7:0] cnt);
      @(posedge clk);
      #1;
      core_r.done = d;
      core_r.failed = f;
      core_r.irq_evt = ev;
      core_r.err_bits = eb;
      tf_load = d;
      tf_r = {cnt, 8'h78, 8'h56, 8'h34, 4'h5};
      @(posedge clk);
      #1;
      core_r.done = 1'b0;
      core_r.failed = 1'b0;
      core_r.irq_evt = 1'b0;
      tf_load = 1'b0;
      @(posedge clk);
      #1;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      core_r = '0;
      tf_load = 1'b0;
      tf_r = '0;
      repeat (12) @(posedge clk);
      #1;
      rstn = 1'b1;
      // Reset defaults
      rd_chk(4'h7, 1'b0, 16'h0000);
      rd_chk(4'h2, 1'b0, 16'h0001);
      rd_chk(4'h6, 1'b0, 16'h00a0);
      rd_chk(4'h1, 1'b0, 16'h0000);
      `CHK(host_irq, 1'b0)
      // Ordinary register rows
      for (int i = 0; i < 6; i++) begin
         wr(row_addr[i], row_data[i]);
         rd_chk(row_addr[i], 1'b0, {8'h00, row_data[i]});
         if (i == 4) begin
            `CHK(drive_select_bit, 1'b1)
         end
      end
      `CHK(sector_total, 9'h100)
      `CHK(block_addr, 28'h5345678)
      `CHK(lba_mode, 1'b1)
      `CHK(head_num, 4'h5)
      `CHK(drive_select_bit, 1'b0)
      // Drive address readback, idle then writing with drive 1
      rd_chk(4'hf, 1'b0, 16'h006a);
      wr(4'h6, 8'hf2);
      core_r.write_active = 1'b1;
      rd_chk(4'hf, 1'b0, 16'h0035);
      core_r.write_active = 1'b0;
      wr(4'h6, 8'he5);
      // Status flags from the engine
      core_r.ready = 1'b1;
      core_r.write_fault = 1'b1;
      core_r.xfer_req = 1'b1;
      core_r.corrected = 1'b1;
      rd_chk(4'h7, 1'b0, 16'h007c);
      rd_chk(4'he, 1'b0, 16'h007c);
      core_r.write_fault = 1'b0;
      core_r.corrected = 1'b0;
      core_r.dma_want = 1'b1;
      @(posedge clk) #1;
      `CHK(dma_req, 1'b1)
      core_r.xfer_req = 1'b0;
      @(posedge clk) #1;
      `CHK(dma_req, 1'b0)
      core_r.busy = 1'b1;
      @(posedge clk) #1;
      `CHK(dma_req, 1'b1)
      core_r.dma_want = 1'b0;
      // Busy lockout, device control still writable
      rd_chk(4'h7, 1'b0, 16'h00d0);
      wr(4'h3, 8'h11);
      wr(4'he, 8'h02); // Host writes ignored bits as zero
      core_r.busy = 1'b0;
      rd_chk(4'h3, 1'b0, 16'h0078);
      // Masked interrupt, then unmasked, then cleared by status read
      engine(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      `CHK(host_irq, 1'b0)
      wr(4'he, 8'h00);
      `CHK(host_irq, 1'b1)
      rd_chk(4'he, 1'b0, 16'h0050);
      `CHK(host_irq, 1'b1)
      rd_chk(4'h7, 1'b0, 16'h0050);
      `CHK(host_irq, 1'b0)
      // Failed command with remaining count
      engine(1'b1, 1'b1, 1'b0, 8'hff, 8'h03);
      rd_chk(4'h1, 1'b0, 16'h00d5);
      rd_chk(4'h0, 1'b1, 16'hd500);
      rd_chk(4'hd, 1'b0, 16'h00d5);
      rd_chk(4'h7, 1'b0, 16'h0051);
      rd_chk(4'h2, 1'b0, 16'h0003);
      engine(1'b1, 1'b1, 1'b0, 8'h04, 8'h01);
      rd_chk(4'h1, 1'b0, 16'h0004);
      // Command write clears the error, success leaves count zero
      wr(4'h7, 8'hc8);
      `CHK(cmd_strobe, 1'b1)
      `CHK(cmd_code, 8'hc8)
      rd_chk(4'h1, 1'b0, 16'h0000);
      engine(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
      rd_chk(4'h2, 1'b0, 16'h0000);
      rd_chk(4'h7, 1'b0, 16'h0050);
      // Feature byte on the high lane of offset 0
      host_feature();
      `CHK(feature_out, 8'h3c)
      // Soft reset holds defaults until released
      engine(1'b1, 1'b1, 1'b0, 8'h40, 8'h02);
      wr(4'he, 8'h04);
      `CHK(soft_reset_bit, 1'b1)
      rd_chk(4'h7, 1'b0, 16'h0080);
      rd_chk(4'h2, 1'b0, 16'h0001);
      wr(4'h3, 8'h22);
      wr(4'he, 8'h00);
      `CHK(soft_reset_bit, 1'b0)
      rd_chk(4'h3, 1'b0, 16'h0001);
      rd_chk(4'h1, 1'b0, 16'h0000);
      wr(4'he, 8'h02);
      rstn = 1'b0;
      @(posedge clk) #1;
      rstn = 1'b1;
      engine(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      `CHK(host_irq, 1'b1)
      rd_chk(4'h6, 1'b0, 16'h00a0);
      give_verdict();
   end
   // High lane feature write at offset 0
   task automatic host_feature();
      logic [15:0] q;
      logic oe;
      host.access(4'h0, 1'b1, 1'b1, 16'h3c00, q, oe);
   endtask
endmodule
